/* design/ienpm_top.sv */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ienpm_consts.svh"

module ienpm_top #(
	parameter int ADDR_W      = 8,
	parameter int WAKE_CYCLES = `IENPM_WAKE_CYC
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// interrupt sources
	input  wire logic              ext_pin_a_n,
	input  wire logic              ext_pin_b_n,
	input  wire logic              timer_a_ovf,
	input  wire logic              timer_b_ovf,
	input  wire logic              timer_c_ovf,
	input  wire logic              timer_c_ext,
	input  wire logic              uart_irq,
	// cpu core side
	output logic [5:0]             irq_req,
	output logic                   irq_valid,
	input  wire logic              irq_ack,
	input  wire logic [2:0]        irq_ack_id,
	input  wire logic              instr_done,
	output logic                   cpu_halt,
	output logic                   periph_run,
	output logic                   osc_run,
	output logic                   ram_write_inhibit,
	output logic                   sfr_reset,
	input  wire logic              reset_pin,
	// pin control
	input  wire logic              core_ale,
	input  wire logic              core_program_store_enable,
	input  wire logic              core_p0_oe,
	input  wire logic              core_p2_addr,
	output logic                   ale_pin,
	output logic                   program_store_enable,
	output logic                   port0_oe,
	output logic                   port2_addr_sel,
	// spi pins
	output logic                   spi_sck,
	output logic                   spi_mosi,
	input  wire logic              spi_miso
);

	initial if (ADDR_W < 5 || ADDR_W > 32) $error("address width not supported");

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a[ADDR_W-1:2] == (ADDR_W-2)'(off[7:2]);
	endfunction : hit

	ienpm_pkg::ienpm_pmode_t pmode;
	ienpm_pkg::ienpm_pmode_t next_pmode;

	logic [7:0]        interrupt_enable_mask;
	logic [6:0]        flg;
	logic [3:0]        evt;
	logic [4:0]        pwr;
	logic              spi_irq_enable;
	logic [5:0]        src;
	logic [5:0]        poll;
	logic              div;
	logic [2:0]        phase;
	logic              tick;
	logic              at_s5;
	logic              at_s2;
	logic              pa_q;
	logic              pb_q;
	logic [1:0]        mc_cnt;
	logic              aw_got;
	logic              w_got;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_do;
	logic              spi_start;
	logic              spi_busy;
	logic              spi_done;
	logic [7:0]        spi_rdata;
	logic              wake_start;
	logic              wake_done;
	logic              pd_wake_src;
	logic [31:0]       rd_mux;
	logic              rd_hit;
	logic [6:0]        w1c;
	logic [6:0]        ackc;
	logic [6:0]        setm;

	// machine timing: oscillator halved into states, six states a cycle
	assign osc_run = (pmode != ienpm_pkg::pm_pdown);
	assign tick    = osc_run && div;
	assign at_s5   = tick && (phase == `IENPM_PH_S5);
	assign at_s2   = tick && (phase == `IENPM_PH_S2);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div   <= 1'b0;
			phase <= 3'h0;
		end
		else if (osc_run)
		begin
			div <= ~div;
			if (div)
				phase <= (phase == `IENPM_PH_LAST) ? 3'h0 : phase + 3'h1;
		end
	end

	// axi write channel: address and data taken in any order
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign wr_do         = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got   <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got   <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (hit(awaddr_q, `IENPM_OFF_MASK) ||
					hit(awaddr_q, `IENPM_OFF_FLAGS) || hit(awaddr_q, `IENPM_OFF_PWR) ||
					hit(awaddr_q, `IENPM_OFF_SPI_DATA) || hit(awaddr_q, `IENPM_OFF_SPI_CTRL) ||
					hit(awaddr_q, `IENPM_OFF_STATUS)) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers; sfr_reset reinitialises them, ram is outside
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sfr_reset)
		begin
			interrupt_enable_mask <= `IENPM_MASK_RST;
			pwr                   <= 5'h00;
			spi_irq_enable        <= 1'b0;
		end
		else
		begin
			if (wr_do && wstrb_q[0] && hit(awaddr_q, `IENPM_OFF_MASK))
			begin
				interrupt_enable_mask <= wdata_q[7:0];
				// reserved bit not stored, reads zero whatever is written
				interrupt_enable_mask[`IENPM_B_RSVD] <= 1'b0;
			end
			if (wr_do && wstrb_q[0] && hit(awaddr_q, `IENPM_OFF_PWR))
				pwr <= wdata_q[4:0];
			else if (next_pmode != pmode && pmode == ienpm_pkg::pm_run)
				pwr[`IENPM_P_PDOWN:`IENPM_P_IDLE] <= 2'h0;
			if (wr_do && wstrb_q[0] && hit(awaddr_q, `IENPM_OFF_SPI_CTRL))
				spi_irq_enable <= wdata_q[0];
		end
	end

	assign spi_start = wr_do && wstrb_q[0] && hit(awaddr_q, `IENPM_OFF_SPI_DATA);

	ienpm_spi_master #(
		.BITS (8)
	) u_spi (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick),
		.start   (spi_start),
		.wdata   (wdata_q[7:0]),
		.busy    (spi_busy),
		.done    (spi_done),
		.rdata   (spi_rdata),
		.sck     (spi_sck),
		.mosi    (spi_mosi),
		.miso    (spi_miso)
	);

	// source flags: set wins over software or vector clear
	always_comb
	begin
		w1c  = (wr_do && wstrb_q[0] && hit(awaddr_q, `IENPM_OFF_FLAGS)) ? wdata_q[6:0] : 7'h00;
		ackc = 7'h00;
		// timer c and serial flags stay set on vectoring
		if (irq_ack && irq_ack_id < 3'h4)
			ackc[irq_ack_id[1:0]] = 1'b1;
		setm = 7'h00;
		setm[`IENPM_B_EXT_A]  = pa_q && !ext_pin_a_n && !pwr[`IENPM_P_LVL_A];
		setm[`IENPM_B_EXT_B]  = pb_q && !ext_pin_b_n && !pwr[`IENPM_P_LVL_B];
		setm[`IENPM_B_TIM_A]  = at_s5 && (evt[0] || timer_a_ovf);
		setm[`IENPM_B_TIM_B]  = at_s5 && (evt[1] || timer_b_ovf);
		setm[`IENPM_F_TC_OVF] = at_s2 && (evt[2] || timer_c_ovf);
		setm[`IENPM_F_TC_EXT] = at_s2 && (evt[3] || timer_c_ext);
		setm[`IENPM_F_SPI]    = spi_done;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || sfr_reset)
		begin
			flg  <= 7'h00;
			evt  <= 4'h0;
			pa_q <= 1'b1;
			pb_q <= 1'b1;
		end
		else
		begin
			flg  <= (flg & ~w1c & ~ackc) | setm;
			pa_q <= ext_pin_a_n;
			pb_q <= ext_pin_b_n;
			// overflows wait here for their setting phase
			evt <= (evt | {timer_c_ext, timer_c_ovf, timer_b_ovf, timer_a_ovf}) &
				~{setm[`IENPM_F_TC_EXT], setm[`IENPM_F_TC_OVF],
				setm[`IENPM_B_TIM_B], setm[`IENPM_B_TIM_A]};
		end
	end

	// six sources in vector order; level mode reads the pin itself
	always_comb
	begin
		src                   = flg[5:0];
		src[`IENPM_B_EXT_A]   = pwr[`IENPM_P_LVL_A] ? !ext_pin_a_n : flg[`IENPM_B_EXT_A];
		src[`IENPM_B_EXT_B]   = pwr[`IENPM_P_LVL_B] ? !ext_pin_b_n : flg[`IENPM_B_EXT_B];
		src[`IENPM_B_SERIAL]  = uart_irq || (flg[`IENPM_F_SPI] && spi_irq_enable);
		src[`IENPM_B_TIM_C]   = flg[`IENPM_F_TC_OVF] || flg[`IENPM_F_TC_EXT];
	end

	// one poll point per machine cycle, at S5P2
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sfr_reset)
			poll <= 6'h00;
		else if (at_s5)
			poll <= src;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_gate
			always_ff @(posedge aclk)
			begin
				if (!aresetn || sfr_reset)
					irq_req[gi] <= 1'b0;
				else
					irq_req[gi] <= poll[gi] && interrupt_enable_mask[gi] &&
						interrupt_enable_mask[`IENPM_B_GLOBAL];
			end
		end
	endgenerate

	assign irq_valid = |irq_req;

	// an enabled external pin in level mode ends power-down
	assign pd_wake_src = interrupt_enable_mask[`IENPM_B_GLOBAL] && (
		(interrupt_enable_mask[`IENPM_B_EXT_A] && pwr[`IENPM_P_LVL_A] && !ext_pin_a_n) ||
		(interrupt_enable_mask[`IENPM_B_EXT_B] && pwr[`IENPM_P_LVL_B] && !ext_pin_b_n));
	assign wake_start = (pmode == ienpm_pkg::pm_pdown) && pd_wake_src && !reset_pin;

	ienpm_wake_timer #(
		.CYCLES (WAKE_CYCLES)
	) u_wake (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (wake_start),
		.busy    (),
		.done    (wake_done)
	);

	// power mode sequencing
	always_comb
	begin
		next_pmode = pmode;
		case (pmode)
			ienpm_pkg::pm_run:
				if (instr_done && pwr[`IENPM_P_PDOWN])
					next_pmode = ienpm_pkg::pm_pdown;
				else if (instr_done && pwr[`IENPM_P_IDLE])
					next_pmode = ienpm_pkg::pm_idle;
			ienpm_pkg::pm_idle:
				if (reset_pin)
					next_pmode = ienpm_pkg::pm_idle_rst;
				else if (irq_valid)
					next_pmode = ienpm_pkg::pm_run;
			ienpm_pkg::pm_idle_rst:
				if (mc_cnt == `IENPM_RST_MC)
					next_pmode = ienpm_pkg::pm_run;
			ienpm_pkg::pm_pdown:
				if (reset_pin)
					next_pmode = ienpm_pkg::pm_run;
				else if (wake_start)
					next_pmode = ienpm_pkg::pm_pd_wake;
			ienpm_pkg::pm_pd_wake:
				if (wake_done)
					next_pmode = ienpm_pkg::pm_run;
			default:
				next_pmode = ienpm_pkg::pm_run;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pmode     <= ienpm_pkg::pm_run;
			mc_cnt    <= 2'h0;
			sfr_reset <= 1'b0;
		end
		else
		begin
			pmode <= next_pmode;
			// reset from power-down at once, from idle after the window
			sfr_reset <= (pmode == ienpm_pkg::pm_pdown && reset_pin) ||
				(pmode == ienpm_pkg::pm_run && reset_pin) ||
				(pmode == ienpm_pkg::pm_idle_rst && mc_cnt == `IENPM_RST_MC);
			if (pmode != ienpm_pkg::pm_idle_rst)
				mc_cnt <= 2'h0;
			else if (tick && phase == `IENPM_PH_LAST)
				mc_cnt <= mc_cnt + 2'h1;
		end
	end

	// halted core; peripherals keep their clock in every mode but power-down
	assign cpu_halt          = (pmode != ienpm_pkg::pm_run);
	assign periph_run        = osc_run;
	// ports stay live in the window; only ram writes are held off
	assign ram_write_inhibit = (pmode == ienpm_pkg::pm_idle_rst);

	// pin states by mode
	always_comb
	begin
		ale_pin              = core_ale;
		program_store_enable = core_program_store_enable;
		port0_oe             = core_p0_oe;
		port2_addr_sel       = core_p2_addr;
		if (pmode == ienpm_pkg::pm_idle || pmode == ienpm_pkg::pm_idle_rst)
		begin
			ale_pin              = 1'b1;
			program_store_enable = 1'b1;
			port0_oe             = pwr[`IENPM_P_EXTMEM] ? 1'b0 : core_p0_oe;
			port2_addr_sel       = pwr[`IENPM_P_EXTMEM];
		end
		else if (pmode == ienpm_pkg::pm_pdown || pmode == ienpm_pkg::pm_pd_wake)
		begin
			ale_pin              = 1'b0;
			program_store_enable = 1'b0;
			port0_oe             = pwr[`IENPM_P_EXTMEM] ? 1'b0 : core_p0_oe;
			port2_addr_sel       = 1'b0;
		end
	end

	// axi read channel, one cycle to answer
	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		if (hit(s_axi_araddr, `IENPM_OFF_MASK))
			rd_mux[7:0] = interrupt_enable_mask;
		else if (hit(s_axi_araddr, `IENPM_OFF_FLAGS))
			rd_mux[6:0] = flg;
		else if (hit(s_axi_araddr, `IENPM_OFF_PWR))
			rd_mux[4:0] = pwr;
		else if (hit(s_axi_araddr, `IENPM_OFF_SPI_DATA))
			rd_mux[7:0] = spi_rdata;
		else if (hit(s_axi_araddr, `IENPM_OFF_SPI_CTRL))
			rd_mux[1:0] = {spi_busy, spi_irq_enable};
		else if (hit(s_axi_araddr, `IENPM_OFF_STATUS))
			rd_mux[10:0] = {pmode, poll[1:0] & 2'h0, irq_req};
		else
			rd_hit = 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_global_off: assert property (!interrupt_enable_mask[`IENPM_B_GLOBAL] ##1
		!interrupt_enable_mask[`IENPM_B_GLOBAL] |-> !irq_valid)
		else $error("request raised with global enable clear");
	a_source_gate: assert property (irq_req[`IENPM_B_TIM_C] |->
		$past(interrupt_enable_mask[`IENPM_B_TIM_C]) && $past(poll[`IENPM_B_TIM_C]))
		else $error("timer c request without its enable");
	a_timer_c_or: assert property (at_s5 && flg[`IENPM_F_TC_EXT] && !sfr_reset |=>
		poll[`IENPM_B_TIM_C])
		else $error("timer c external flag not polled");
	a_timer_a_phase: assert property ($rose(flg[`IENPM_B_TIM_A]) |->
		$past(phase) == `IENPM_PH_S5 && $past(div))
		else $error("timer a flag set outside S5P2");
	a_timer_c_keep: assert property (flg[`IENPM_F_TC_OVF] && irq_ack && !w1c[5] && !sfr_reset
		|=> flg[`IENPM_F_TC_OVF])
		else $error("timer c flag cleared by vectoring");
	a_idle_wake: assert property (pmode == ienpm_pkg::pm_idle && irq_valid && !reset_pin
		|=> pmode == ienpm_pkg::pm_run)
		else $error("enabled interrupt did not end idle");
	a_pd_pins: assert property (pmode == ienpm_pkg::pm_pdown |-> !ale_pin &&
		!program_store_enable && !tick && !periph_run)
		else $error("power-down pins or clock wrong");
	a_rst_window: assert property ($rose(ram_write_inhibit) |-> ram_write_inhibit [*8])
		else $error("ram inhibit window too short");
	a_idle_halt: assert property (pmode == ienpm_pkg::pm_idle |-> cpu_halt && periph_run
		&& ale_pin && program_store_enable)
		else $error("idle state outputs wrong");

endmodule : ienpm_top

/* pkg/ienpm_consts.svh */
`ifndef IENPM_CONSTS_SVH
`define IENPM_CONSTS_SVH

// register byte offsets
`define IENPM_OFF_MASK     8'h00
`define IENPM_OFF_FLAGS    8'h04
`define IENPM_OFF_PWR      8'h08
`define IENPM_OFF_SPI_DATA 8'h0c
`define IENPM_OFF_SPI_CTRL 8'h10
`define IENPM_OFF_STATUS   8'h14

// enable mask bits, also the source index of each vector
`define IENPM_B_EXT_A   0
`define IENPM_B_TIM_A   1
`define IENPM_B_EXT_B   2
`define IENPM_B_TIM_B   3
`define IENPM_B_SERIAL  4
`define IENPM_B_TIM_C   5
`define IENPM_B_RSVD    6
`define IENPM_B_GLOBAL  7
`define IENPM_MASK_RST  8'h00

// flag register bits (0..4 follow the source index)
`define IENPM_F_SPI     4
`define IENPM_F_TC_OVF  5
`define IENPM_F_TC_EXT  6

// power control bits
`define IENPM_P_IDLE    0
`define IENPM_P_PDOWN   1
`define IENPM_P_LVL_A   2
`define IENPM_P_LVL_B   3
`define IENPM_P_EXTMEM  4

// machine cycle phases: six states of two clocks
`define IENPM_PH_S2     3'h1
`define IENPM_PH_S5     3'h4
`define IENPM_PH_LAST   3'h5
`define IENPM_RST_MC    2'h2

// wake delay after an interrupt leaves power-down
`define IENPM_CLK_NS    25
`define IENPM_WAKE_NS   16000000
`define IENPM_WAKE_CYC  (`IENPM_WAKE_NS / `IENPM_CLK_NS)

`endif

/* pkg/ienpm_pkg.sv */
package ienpm_pkg;

	typedef enum logic [2:0]
	{
		pm_run,
		pm_idle,
		pm_idle_rst,
		pm_pdown,
		pm_pd_wake
	} ienpm_pmode_t;

endpackage : ienpm_pkg

/* design/ienpm_spi_master.sv */
`timescale 1ns/1ps
module ienpm_spi_master #(
	parameter int BITS = 8
) (
	// clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// control
	input  wire logic            tick,
	input  wire logic            start,
	input  wire logic [BITS-1:0] wdata,
	output logic                 busy,
	output logic                 done,
	output logic      [BITS-1:0] rdata,
	// pins
	output logic                 sck,
	output logic                 mosi,
	input  wire logic            miso
);

	// the shifter reads bit BITS-2, so a one-bit frame cannot be served
	initial if (BITS < 2 || BITS > 16) $error("spi width not supported");

	logic [BITS-1:0] shreg;
	logic [4:0]      left;

	// clock runs only while a byte is in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy  <= 1'b0;
			done  <= 1'b0;
			sck   <= 1'b0;
			mosi  <= 1'b0;
			shreg <= '0;
			rdata <= '0;
			left  <= 5'h00;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy  <= 1'b1;
				shreg <= wdata;
				mosi  <= wdata[BITS-1];
				left  <= 5'(BITS);
			end
			else if (busy && tick)
			begin
				sck <= ~sck;
				if (sck)
				begin
					shreg <= {shreg[BITS-2:0], 1'b0};
					mosi  <= shreg[BITS-2];
					left  <= left - 5'h01;
					if (left == 5'h01)
					begin
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
				else
				begin
					rdata <= {rdata[BITS-2:0], miso};
				end
			end
		end
	end

	a_spi_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		done |-> !busy && !sck && $past(busy))
		else $error("spi clock did not stop at end of byte");

endmodule : ienpm_spi_master

/* design/ienpm_wake_timer.sv */
`timescale 1ns/1ps
module ienpm_wake_timer #(
	parameter int CYCLES = 640000
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam int W = $clog2(CYCLES + 1);

	initial if (CYCLES < 1) $error("wake delay must be at least one cycle");

	logic [W-1:0] cnt;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy <= 1'b1;
				cnt  <= W'(CYCLES - 1);
			end
			else if (busy)
			begin
				if (cnt == '0)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else
				begin
					cnt <= cnt - 1'b1;
				end
			end
		end
	end

endmodule : ienpm_wake_timer

/* test/ienpm_core_model.sv */
`timescale 1ns/1ps
module ienpm_core_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// interrupt sequencer
	input  wire logic [5:0] irq_req,
	input  wire logic       ack_en,
	output logic            irq_ack,
	output logic [2:0]      irq_ack_id
);
	logic [2:0] lowest;

	// lowest vector wins; real priority order is not needed for these checks
	always_comb
	begin
		lowest = 3'h0;
		for (int i = 5; i >= 0; i--)
			if (irq_req[i])
				lowest = 3'(i);
	end

	// one ack then a gap, so a flag that the device clears can drop first
	always_ff @(posedge aclk)
	begin
		if (!aresetn || irq_ack)
			irq_ack <= 1'b0;
		else
			irq_ack <= ack_en && (irq_req != 6'h00);
		irq_ack_id <= lowest; // timer c flags are left to software
	end
endmodule : ienpm_core_model

/* test/interrupt_enable_power_modes_test.sv */
`timescale 1ns/1ps
module interrupt_enable_power_modes_test;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic ext_pin_a_n = 1, ext_pin_b_n = 1, timer_a_ovf = 0, timer_b_ovf = 0;
	logic timer_c_ovf = 0, timer_c_ext = 0, uart_irq = 0, ack_en = 0, instr_done = 0;
	logic [5:0] irq_req;
	logic [2:0] irq_ack_id;
	logic irq_valid, irq_ack, cpu_halt, periph_run, osc_run, ram_write_inhibit, sfr_reset;
	logic reset_pin = 0, core_ale = 0, core_program_store_enable = 0, core_p0_oe = 1, core_p2_addr = 0;
	logic ale_pin, program_store_enable, port0_oe, port2_addr_sel, spi_sck, spi_mosi;
	logic spi_miso = 1;
	logic [7:0] mosi_sh = 8'h00;
	int errors = 0, n_compared = 0, cyc = 0, n, v;

	always #12.5 aclk = ~aclk;

	// far-side shifter: mosi moves only at frame start and on the falling sck edge, so it is settled here
	always @(posedge spi_sck)
		mosi_sh <= {mosi_sh[6:0], spi_mosi};

	ienpm_top #(.WAKE_CYCLES(20)) i_dut (.*);
	ienpm_core_model i_core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
		.ack_en(ack_en), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id));

	task give_verdict;
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// hang guard, well above the length of the sequence below
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// both channels offered together, each released at its own handshake
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pw = 1;
		while (pa || pw)
		begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask : wr

	task rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask : rdr

	// pins held a whole machine cycle so edge sampling cannot miss them
	task src(input int i);
		@(posedge aclk);
		case (i)
			0: ext_pin_a_n <= 0;
			1: timer_a_ovf <= 1;
			2: ext_pin_b_n <= 0;
			3: timer_b_ovf <= 1;
			4: uart_irq <= 1;
			5: timer_c_ovf <= 1;
			default: timer_c_ext <= 1;
		endcase
		repeat ((i == 0 || i == 2) ? 12 : 1) @(posedge aclk);
		{ext_pin_a_n, ext_pin_b_n} <= 2'b11;
		{timer_a_ovf, timer_b_ovf, timer_c_ovf, timer_c_ext} <= 4'h0;
	endtask : src

	task idle_n(input int k);
		repeat (k) @(negedge aclk);
	endtask : idle_n

	task ack(input int k);
		@(posedge aclk);
		ack_en <= 1;
		repeat (k) @(posedge aclk);
		ack_en <= 0;
	endtask : ack

	task step;
		@(posedge aclk);
		instr_done <= 1;
		@(posedge aclk);
		instr_done <= 0;
	endtask : step

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rdr(8'h00); chk(rd, 32'h0);
		wr(8'h00, 32'hbf); rdr(8'h00); chk(rd, 32'hbf);
		rdr(8'h1c); chk({30'h0, rs}, 32'h2);
		for (int i = 0; i < 7; i++)
		begin
			v = (i == 6) ? 5 : i;
			wr(8'h00, 32'hbf & ~(32'h1 << v));
			src(i);
			idle_n(40); chk(irq_req, 6'h00);
			wr(8'h00, 32'h1 << v);
			idle_n(40); chk(irq_req, 6'h00);
			wr(8'h00, 32'h80 | (32'h1 << v));
			idle_n(40); chk(irq_req, 6'h1 << v);
			ack(20);
			idle_n(40); chk(irq_req, (v >= 4) ? 6'h1 << v : 6'h00);
			@(posedge aclk);
			uart_irq <= 0;
			wr(8'h04, 32'h60);
			idle_n(40); chk(irq_req, 6'h00);
		end
		wr(8'h00, 32'h90);
		wr(8'h0c, 32'ha5);
		idle_n(60); chk(irq_req, 6'h00);
		wr(8'h04, 32'h10);
		wr(8'h10, 32'h1);
		wr(8'h0c, 32'h5a);
		idle_n(60); chk({spi_sck, irq_valid, irq_req}, 8'h50);
		chk(mosi_sh, 8'h5a);
		rdr(8'h0c); chk(rd, 32'hff);
		wr(8'h04, 32'h10);
		wr(8'h00, 32'h82);
		wr(8'h08, 32'h1);
		step();
		idle_n(2);
		chk({cpu_halt, periph_run, ale_pin, program_store_enable, port0_oe, port2_addr_sel},
			6'h3e);
		src(1);
		n = 0;
		do begin @(negedge aclk); n++; end while (cpu_halt !== 1'b0 && n < 40);
		chk(cpu_halt, 1'b0);
		ack(20);
		wr(8'h00, 32'h81);
		wr(8'h08, 32'h06); // level mode set before entry
		step();
		idle_n(2);
		chk({osc_run, ale_pin, program_store_enable, port0_oe, port2_addr_sel}, 5'h02);
		@(posedge aclk);
		ext_pin_a_n <= 0;
		// clock restarts for the wake count, core stays halted until it ends
		idle_n(15); chk({osc_run, cpu_halt, ale_pin}, 3'b110);
		n = 15;
		do begin @(negedge aclk); n++; end while (cpu_halt !== 1'b0 && n < 40);
		chk(n >= 20 && n <= 25, 1'b1);
		@(posedge aclk);
		ext_pin_a_n <= 1;
		ack(20);
		// external program memory this time, so idle pins differ from the run values
		wr(8'h08, 32'h11);
		step(); // next step writes no port
		@(posedge aclk);
		reset_pin <= 1;
		idle_n(3); chk({ram_write_inhibit, port0_oe, port2_addr_sel}, 3'b101);
		n = 0;
		do begin @(negedge aclk); n++; end while (sfr_reset !== 1'b1 && n < 40);
		chk(n >= 13 && n <= 24, 1'b1);
		@(posedge aclk);
		reset_pin <= 0;
		rdr(8'h00); chk(rd, 32'h0);
		give_verdict();
	end
endmodule : interrupt_enable_power_modes_test
